// ### core/lbft_pkg.sv
// Package of the break-field trigger and status block: offsets, bit
// positions, reset values and serial timing for one LIN-capable channel.
// Assumes an 8-bit register port with a 5-bit byte address.
package lbft_pkg;

    localparam logic [4:0] OFS_TRIG  = 5'h04;
    localparam logic [4:0] OFS_STAT0 = 5'h08;
    localparam logic [4:0] OFS_STAT1 = 5'h0C;
    localparam logic [4:0] OFS_CLR   = 5'h10;
    localparam logic [4:0] OFS_TXD   = 5'h14;

    localparam int BIT_BRX  = 6;
    localparam int BIT_BTX  = 5;
    localparam int BIT_RXB  = 1;
    localparam int BIT_TXP  = 0;
    localparam int BIT_DONE = 4;
    localparam int BIT_DCE  = 3;

    localparam logic [7:0] STAT0_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    localparam int BIT_CYC     = 16;
    localparam int BRK_TX_BITS = 13;
    localparam int BRK_RX_BITS = 11;
    localparam int DATA_BITS   = 8;
    localparam int STOP_IDX    = DATA_BITS + 1;

endpackage

// ### core/lbft_tx_shift.sv
// Serial shifter: sends one 8N1 data frame or one break field plus delimiter.
// Assumes starts come only while idle; kill drops a frame at once.
`timescale 1ns/1ps
module lbft_tx_shift
    import lbft_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC,
    parameter int BRK_BITS   = BRK_TX_BITS
) (
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       kill_in,
    input  wire logic       start_brk_in,
    input  wire logic       start_data_in,
    input  wire logic [7:0] data_in,
    output logic            txd_out,
    output logic            busy_out,
    output logic            brk_busy_out,
    output logic            done_brk_out,
    output logic            done_data_out
);
    localparam int SW = BRK_BITS + 1;

    logic [SW-1:0] sh_r;
    logic [15:0]   phase_r;
    logic [7:0]    left_r;
    logic          brk_r;
    logic          last_bit;

    assign last_bit = (left_r == 8'h01) && (phase_r == 16'(BIT_CYCLES - 1));

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sh_r    <= '1;
            phase_r <= 16'h0000;
            left_r  <= 8'h00;
            brk_r   <= 1'b0;
        end else if (kill_in) begin
            sh_r    <= '1;
            left_r  <= 8'h00;
            brk_r   <= 1'b0;
        end else if (start_brk_in) begin
            // Delimiter bit sits above the low break bits
            sh_r    <= {1'b1, {BRK_BITS{1'b0}}};
            phase_r <= 16'h0000;
            left_r  <= 8'(SW);
            brk_r   <= 1'b1;
        end else if (start_data_in) begin
            sh_r    <= SW'({1'b1, data_in, 1'b0});
            phase_r <= 16'h0000;
            left_r  <= 8'(DATA_BITS + 2);
            brk_r   <= 1'b0;
        end else if (left_r != 8'h00) begin
            if (phase_r == 16'(BIT_CYCLES - 1)) begin
                phase_r <= 16'h0000;
                sh_r    <= {1'b1, sh_r[SW-1:1]};
                left_r  <= left_r - 8'h01;
            end else begin
                phase_r <= phase_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_brk_out  <= 1'b0;
            done_data_out <= 1'b0;
        end else begin
            done_brk_out  <= !kill_in && last_bit && brk_r;
            done_data_out <= !kill_in && last_bit && !brk_r;
        end
    end

    assign txd_out      = (left_r == 8'h00) ? 1'b1 : sh_r[0];
    assign busy_out     = (left_r != 8'h00);
    assign brk_busy_out = busy_out && brk_r;
endmodule

// ### core/lbft_brk_det.sv
// Break-field detector: measures how long the receive line stays low.
// The low counter runs whether or not a break is armed, so a reception
// aborted by a trigger keeps the low time it has already measured.
`timescale 1ns/1ps
module lbft_brk_det
    import lbft_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC,
    parameter int BRK_BITS   = BRK_RX_BITS
) (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic rxd_in,
    input  wire logic armed_in,
    output logic      done_out
);
    localparam logic [23:0] LOW_MAX = 24'(BIT_CYCLES * BRK_BITS);

    logic [23:0] low_r;
    logic        rxd_d_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            low_r   <= 24'h000000;
            rxd_d_r <= 1'b1;
        end else begin
            rxd_d_r <= rxd_in;
            if (rxd_in) begin
                low_r <= 24'h000000;
            end else if (low_r != LOW_MAX) begin
                low_r <= low_r + 24'h000001;
            end
        end
    end

    // Done on the rising edge that ends a long enough low
    assign done_out = armed_in && rxd_in && !rxd_d_r && (low_r == LOW_MAX);
endmodule

// ### core/lbft_top.sv
// Break-field trigger and status logic of one LIN-capable UART channel.
// Assumes synchronous inputs, an 8-bit register port and enables from a
// control register that lives outside this block.
// Behaviour
// - Break receive trigger with receive enabled arms break reception in the next cycle.
// - Break receive trigger aborts ongoing reception; nothing stored, no interrupt.
// - Both trigger bits read zero; writing zero to them does nothing.
// - Mode select 0: finished armed break reception raises receive interrupt.
// - Mode select 1: finished break sets done flag and raises status interrupt.
// - Break transmit trigger accepted when unarmed, enabled, and no blocking error.
// - Trigger during data frame sends break afterwards; repeats give one break.
// - Accepted break trigger drops pending data; later data follows the break.
// - Break and data both pending at start: break goes first.
// - Consistency error set and check mode low: break transmit trigger ignored.
// - Break transmit trigger with receive enabled also arms break reception.
// - Status register takes writes only while power enable is low.
// - Status register clears on reset and when power enable drops.
// - Bit 6 shows break reception armed; cleared when receive enable low.
// - Bit 5 shows break transmission armed, waiting or sending.
// - Bit 1 shows data reception in progress.
// - Bit 0 shows transmit data pending or being shifted.
// - Bits 5, 1 and 0 clear when transmit enable is low.
// - Writing one to clear-break-done clears the done flag; zero ignored.
// - Consistency error flag reads one once an error was detected.
`timescale 1ns/1ps
module lbft_top
    import lbft_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
) (
    input  wire logic       CLK_IN,
    input  wire logic       ARST_N_IN,
    input  wire logic [4:0] REG_ADDR_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    output logic      [7:0] REG_RDATA_OUT,
    input  wire logic       POWER_EN_IN,
    input  wire logic       RX_EN_IN,
    input  wire logic       TX_EN_IN,
    input  wire logic       BREAK_MODE_IN,
    input  wire logic       CHECK_MODE_IN,
    input  wire logic       CONSIST_ERR_IN,
    input  wire logic       RXD_IN,
    output logic            TXD_OUT,
    output logic      [7:0] RX_DATA_OUT,
    output logic            RX_IRQ_OUT,
    output logic            STATUS_IRQ_OUT
);
    typedef enum logic {RX_IDLE, RX_BUSY} lbft_rx_t;

    lbft_rx_t    rx_st_r;
    logic [15:0] rx_ph_r;
    logic [3:0]  rx_idx_r;
    logic [7:0]  rx_sh_r;
    logic        rxd_d_r;
    logic        pw_d_r;
    logic        brx_armed_r;
    logic        btx_armed_r;
    logic        rx_busy_r;
    logic        tx_pend_r;
    logic        done_r;
    logic        dce_r;
    logic        brk_req_r;
    logic        data_req_r;
    logic [7:0]  data_byte_r;
    logic        tx_pend_nxt;
    logic        wr_trig;
    logic        wr_stat0;
    logic        wr_clr;
    logic        txd_wr;
    logic        brt_hit;
    logic        btt_ok;
    logic        brx_go;
    logic        pw_fall;
    logic        rx_on;
    logic        tx_on;
    logic        start_brk;
    logic        start_data;
    logic        tx_busy;
    logic        tx_brk_busy;
    logic        tx_done_brk;
    logic        tx_done_data;
    logic        brk_done;
    logic        rx_fall;
    logic        rx_mid;
    logic        rx_fin_ok;
    logic        brk_det_done;

    assign rx_on    = POWER_EN_IN && RX_EN_IN;
    assign tx_on    = POWER_EN_IN && TX_EN_IN;
    assign pw_fall  = pw_d_r && !POWER_EN_IN;
    assign wr_trig  = REG_WR_IN && (REG_ADDR_IN == OFS_TRIG);
    assign wr_stat0 = REG_WR_IN && (REG_ADDR_IN == OFS_STAT0) && !POWER_EN_IN;
    assign wr_clr   = REG_WR_IN && (REG_ADDR_IN == OFS_CLR);
    assign txd_wr   = REG_WR_IN && (REG_ADDR_IN == OFS_TXD) && tx_on;

    // Only a written one acts; a zero bit is no event at all
    assign brt_hit = wr_trig && REG_WDATA_IN[BIT_BRX];
    // Armed status blocks repeats, so only one break goes out
    assign btt_ok  = wr_trig && REG_WDATA_IN[BIT_BTX] && tx_on && !btx_armed_r
                     && (CHECK_MODE_IN || !dce_r);
    assign brx_go  = rx_on && (brt_hit || btt_ok);

    // Break wins at a start; starts only wait for the shifter to go idle
    assign start_brk  = tx_on && !tx_busy && brk_req_r;
    assign start_data = tx_on && !tx_busy && !brk_req_r && data_req_r;

    assign brk_done = rx_on && brx_armed_r && brk_det_done;

    lbft_brk_det #(
        .BIT_CYCLES (BIT_CYCLES),
        .BRK_BITS   (BRK_RX_BITS)
    ) u_brk_det (
        .clk_in    (CLK_IN),
        .arst_n_in (ARST_N_IN),
        .rxd_in    (RXD_IN),
        .armed_in  (brx_armed_r),
        .done_out  (brk_det_done)
    );

    lbft_tx_shift #(
        .BIT_CYCLES (BIT_CYCLES),
        .BRK_BITS   (BRK_TX_BITS)
    ) u_tx_shift (
        .clk_in        (CLK_IN),
        .arst_n_in     (ARST_N_IN),
        .kill_in       (!tx_on),
        .start_brk_in  (start_brk),
        .start_data_in (start_data),
        .data_in       (data_byte_r),
        .txd_out       (TXD_OUT),
        .busy_out      (tx_busy),
        .brk_busy_out  (tx_brk_busy),
        .done_brk_out  (tx_done_brk),
        .done_data_out (tx_done_data)
    );

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pw_d_r  <= 1'b0;
            rxd_d_r <= 1'b1;
        end else begin
            pw_d_r  <= POWER_EN_IN;
            rxd_d_r <= RXD_IN;
        end
    end

    // Pending requests
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            brk_req_r <= 1'b0;
        end else if (!tx_on) begin
            brk_req_r <= 1'b0;
        end else if (btt_ok) begin
            brk_req_r <= 1'b1;
        end else if (start_brk) begin
            brk_req_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            data_req_r  <= 1'b0;
            data_byte_r <= 8'h00;
        end else if (!tx_on) begin
            data_req_r  <= 1'b0;
        end else if (txd_wr) begin
            // A byte written with or after the trigger queues behind the break
            data_req_r  <= 1'b1;
            data_byte_r <= REG_WDATA_IN;
        end else if (btt_ok || start_data) begin
            data_req_r  <= 1'b0;
        end
    end

    // Status register 0; the power-off write path loads raw bits
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            brx_armed_r <= STAT0_RST[BIT_BRX];
        end else if (pw_fall) begin
            brx_armed_r <= STAT0_RST[BIT_BRX];
        end else if (!POWER_EN_IN) begin
            if (wr_stat0) begin
                brx_armed_r <= REG_WDATA_IN[BIT_BRX];
            end
        end else if (!RX_EN_IN) begin
            brx_armed_r <= 1'b0;
        end else if (brx_go) begin
            brx_armed_r <= 1'b1;
        end else if (brk_done) begin
            brx_armed_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            btx_armed_r <= STAT0_RST[BIT_BTX];
        end else if (pw_fall) begin
            btx_armed_r <= STAT0_RST[BIT_BTX];
        end else if (!POWER_EN_IN) begin
            if (wr_stat0) begin
                btx_armed_r <= REG_WDATA_IN[BIT_BTX];
            end
        end else if (!TX_EN_IN) begin
            btx_armed_r <= 1'b0;
        end else if (btt_ok) begin
            btx_armed_r <= 1'b1;
        end else if (tx_done_brk) begin
            btx_armed_r <= 1'b0;
        end
    end

    assign tx_pend_nxt = txd_wr || (data_req_r && !btt_ok) || start_data
                         || (tx_busy && !tx_brk_busy && !tx_done_data);

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            tx_pend_r <= STAT0_RST[BIT_TXP];
            rx_busy_r <= STAT0_RST[BIT_RXB];
        end else if (pw_fall) begin
            tx_pend_r <= STAT0_RST[BIT_TXP];
            rx_busy_r <= STAT0_RST[BIT_RXB];
        end else if (!POWER_EN_IN) begin
            if (wr_stat0) begin
                tx_pend_r <= REG_WDATA_IN[BIT_TXP];
                rx_busy_r <= REG_WDATA_IN[BIT_RXB];
            end
        end else if (!TX_EN_IN) begin
            tx_pend_r <= 1'b0;
            rx_busy_r <= 1'b0;
        end else begin
            tx_pend_r <= tx_pend_nxt;
            rx_busy_r <= (rx_st_r == RX_BUSY) && !brx_go && !rx_fin_ok && rx_on;
        end
    end

    // Data receiver: 8N1, sampled mid-bit
    assign rx_fall   = rxd_d_r && !RXD_IN;
    assign rx_mid    = (rx_ph_r == 16'(BIT_CYCLES / 2));
    assign rx_fin_ok = (rx_st_r == RX_BUSY) && rx_mid && (rx_idx_r == 4'(STOP_IDX))
                       && RXD_IN && !brx_go;

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rx_st_r  <= RX_IDLE;
            rx_ph_r  <= 16'h0000;
            rx_idx_r <= 4'h0;
            rx_sh_r  <= 8'h00;
        end else begin
            case (rx_st_r)
                RX_IDLE: begin
                    // An armed break owns the line, so no data frame starts
                    if (rx_on && rx_fall && !brx_armed_r && !brx_go) begin
                        rx_st_r  <= RX_BUSY;
                        rx_ph_r  <= 16'h0000;
                        rx_idx_r <= 4'h0;
                    end
                end
                RX_BUSY: begin
                    if (!rx_on || brx_go) begin
                        rx_st_r <= RX_IDLE;
                    end else if (rx_mid && rx_idx_r == 4'(STOP_IDX)) begin
                        rx_st_r <= RX_IDLE;
                    end else if (rx_ph_r == 16'(BIT_CYCLES - 1)) begin
                        rx_ph_r  <= 16'h0000;
                        rx_idx_r <= rx_idx_r + 4'h1;
                    end else begin
                        rx_ph_r <= rx_ph_r + 16'h0001;
                        if (rx_mid && rx_idx_r != 4'h0) begin
                            rx_sh_r <= {RXD_IN, rx_sh_r[7:1]};
                        end
                    end
                end
                default: begin
                    rx_st_r <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RX_DATA_OUT <= 8'h00;
        end else if (rx_fin_ok) begin
            RX_DATA_OUT <= rx_sh_r;
        end
    end

    // Interrupt pulses
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RX_IRQ_OUT     <= 1'b0;
            STATUS_IRQ_OUT <= 1'b0;
        end else begin
            RX_IRQ_OUT     <= rx_fin_ok || (brk_done && !BREAK_MODE_IN);
            STATUS_IRQ_OUT <= brk_done && BREAK_MODE_IN;
        end
    end

    // Status register 1 flags; a set in the same cycle beats any clear
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            done_r <= 1'b0;
        end else if (brk_done && BREAK_MODE_IN) begin
            done_r <= 1'b1;
        end else if (!rx_on || !BREAK_MODE_IN || (wr_clr && REG_WDATA_IN[BIT_DONE])) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            dce_r <= 1'b0;
        end else if (CONSIST_ERR_IN && tx_on) begin
            dce_r <= 1'b1;
        end else if (!tx_on || (wr_clr && REG_WDATA_IN[BIT_DCE])) begin
            dce_r <= 1'b0;
        end
    end

    // Read port; trigger, clear and data offsets read as zero
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            REG_RDATA_OUT <= RDATA_RST;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                OFS_STAT0: REG_RDATA_OUT <= {1'b0, brx_armed_r, btx_armed_r, 3'b000,
                                             rx_busy_r, tx_pend_r};
                OFS_STAT1: REG_RDATA_OUT <= {3'b000, done_r, dce_r, 3'b000};
                default:   REG_RDATA_OUT <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    chk_trig_reads_zero: assert property (
        REG_RD_IN && REG_ADDR_IN == OFS_TRIG |=> REG_RDATA_OUT == 8'h00)
        else $error("trigger offset read returned nonzero");

    chk_brx_arms: assert property (
        rx_on && brt_hit |=> brx_armed_r ##1 brx_armed_r || !rx_on || $past(brk_done))
        else $error("break receive trigger did not arm");

    chk_btx_accept: assert property (
        btt_ok |=> btx_armed_r && brk_req_r && !data_req_r || $past(txd_wr))
        else $error("break transmit trigger not registered");

    chk_btx_ignore: assert property (
        wr_trig && REG_WDATA_IN[BIT_BTX] && dce_r && !CHECK_MODE_IN && !btx_armed_r
        |=> !btx_armed_r)
        else $error("blocked break transmit trigger took effect");

    chk_rx_abort: assert property (
        rx_st_r == RX_BUSY && brx_go |=> rx_st_r == RX_IDLE && !RX_IRQ_OUT
        && $stable(RX_DATA_OUT))
        else $error("reception not aborted cleanly");

    chk_brk_first: assert property (
        brk_req_r && data_req_r && tx_on && !tx_busy |=> tx_brk_busy)
        else $error("data sent ahead of pending break");

    chk_irq_mode0: assert property (
        brk_done && !BREAK_MODE_IN |=> RX_IRQ_OUT && !STATUS_IRQ_OUT && !brx_armed_r)
        else $error("mode 0 break completion not signalled");

    chk_irq_mode1: assert property (
        brk_done && BREAK_MODE_IN |=> done_r && STATUS_IRQ_OUT && !RX_IRQ_OUT)
        else $error("mode 1 break completion not signalled");

    chk_pw_clear: assert property (
        $fell(POWER_EN_IN) |=> !brx_armed_r && !btx_armed_r && !rx_busy_r && !tx_pend_r)
        else $error("status not cleared at power disable");

    chk_txen_clear: assert property (
        POWER_EN_IN && !TX_EN_IN |=> !btx_armed_r && !rx_busy_r && !tx_pend_r)
        else $error("status not cleared with transmit disabled");

    chk_btx_done: assert property (
        tx_done_brk && tx_on |=> !btx_armed_r)
        else $error("break transmit armed after break sent");

    cov_brk_sent: cover property (btt_ok ##[1:300] tx_done_brk);
    cov_brk_rcvd: cover property (brx_go ##[1:1000] brk_done);
    cov_abort:    cover property (rx_st_r == RX_BUSY && brx_go);
    cov_brk_data: cover property (brk_req_r && data_req_r && !tx_busy && tx_on);
endmodule

// ### verif/lbft_node_model.sv
// Remote serial node: drives the receive line and decodes the transmit line.
// Assumes both ends use one bit time of BIT_CYCLES clock cycles.
`timescale 1ns/1ps
module lbft_node_model #(
    parameter int BIT_CYCLES = 4
) (
    input  wire logic clk_in,
    input  wire logic txd_in,
    output logic      rxd_out
);
    logic [8:0] seen_q [$];
    logic [7:0] sh;
    initial rxd_out = 1'b1;
    // A low stop sample means a break; it is logged as 9'h100
    always begin
        @(negedge txd_in);
        repeat (BIT_CYCLES / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_in);
            sh = {txd_in, sh[7:1]};
        end
        repeat (BIT_CYCLES) @(posedge clk_in);
        if (txd_in === 1'b1) begin
            seen_q.push_back({1'b0, sh});
        end else begin
            wait (txd_in === 1'b1);
            seen_q.push_back(9'h100);
        end
    end
    // Bits change just after a rising edge; line returns to idle high
    task automatic send_bits(input logic [15:0] bits, input int n);
        @(posedge clk_in);
        for (int k = 0; k < n; k++) begin
            rxd_out <= bits[k];
            repeat (BIT_CYCLES) @(posedge clk_in);
        end
        rxd_out <= 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] b);
        send_bits({6'h00, 1'b1, b, 1'b0}, 10);
    endtask
    // One unbroken low stretch; a split call would glitch the line high
    task automatic send_break();
        send_bits(16'h0000, 13);
    endtask
endmodule

// ### verif/lbft_top_tb_top.sv
// Self-checking bench of the break-field trigger and status block.
// Assumes a remote node model on the serial lines and a short bit time.
`timescale 1ns/1ps
module lbft_top_tb_top;
    import lbft_pkg::*;
    localparam int BC = 4;
    logic       clk, arst_n, wr, rd, pwr, rxe, txe, bmode, cmode, cerr;
    logic       rxd, txd, rx_irq, st_irq;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, rx_data, v;
    int         fails, comparisons, cycles, n_rx, n_st, n;

    lbft_top #(.BIT_CYCLES(BC)) u_dut (.CLK_IN(clk), .ARST_N_IN(arst_n),
        .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata),
        .REG_RDATA_OUT(rdata), .POWER_EN_IN(pwr), .RX_EN_IN(rxe), .TX_EN_IN(txe),
        .BREAK_MODE_IN(bmode), .CHECK_MODE_IN(cmode), .CONSIST_ERR_IN(cerr),
        .RXD_IN(rxd), .TXD_OUT(txd), .RX_DATA_OUT(rx_data), .RX_IRQ_OUT(rx_irq),
        .STATUS_IRQ_OUT(st_irq));
    lbft_node_model #(.BIT_CYCLES(BC)) u_node (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Interrupts are one-cycle pulses, so they are counted on every rising edge
    always @(posedge clk) begin
        cycles++;
        if (rx_irq === 1'b1) n_rx++;
        if (st_irq === 1'b1) n_st++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk_reg(input string what, input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(what, {1'b0, rdata}, {1'b0, e});
    endtask
    task automatic settle(input int bits);
        repeat (bits * BC) @(posedge clk);
    endtask
    task automatic t_brk_tx();
        n = u_node.seen_q.size();
        wr_reg(OFS_TRIG, 8'h40);
        wr_reg(OFS_TRIG, 8'h20);
        chk_reg("stat0 armed", OFS_STAT0, 8'h60);
        chk_reg("trig read", OFS_TRIG, 8'h00);
        settle(16);
        check("break sent", u_node.seen_q[n], 9'h100);
        chk_reg("stat0 tx done", OFS_STAT0, 8'h40);
        v = n_rx;
        u_node.send_break();
        settle(1);
        check("rx irq mode 0", n_rx, v + 1);
        chk_reg("stat0 rx done", OFS_STAT0, 8'h00);
    endtask
    task automatic t_abort();
        u_node.send_byte(8'h5A);
        settle(1);
        check("rx byte", rx_data, 8'h5A);
        v = n_rx;
        fork
            u_node.send_byte(8'h00);
            begin
                settle(3);
                chk_reg("stat0 rx busy", OFS_STAT0, 8'h02);
                wr_reg(OFS_TRIG, 8'h40);
            end
        join
        settle(2);
        check("aborted irq", n_rx, v);
        check("aborted data", rx_data, 8'h5A);
        chk_reg("stat0 waiting", OFS_STAT0, 8'h40);
        u_node.send_break();
        settle(1);
        check("break after abort", n_rx, v + 1);
    endtask
    task automatic t_mode1();
        @(posedge clk);
        bmode <= 1'b1;
        v = n_st;
        wr_reg(OFS_TRIG, 8'h40);
        u_node.send_break();
        settle(1);
        check("status irq", n_st, v + 1);
        wr_reg(OFS_CLR, 8'h00);
        chk_reg("done kept", OFS_STAT1, 8'h10);
        wr_reg(OFS_CLR, 8'h10);
        chk_reg("done cleared", OFS_STAT1, 8'h00);
        @(posedge clk);
        bmode <= 1'b0;
    endtask
    task automatic t_order();
        n = u_node.seen_q.size();
        wr_reg(OFS_TXD, 8'h11);
        wr_reg(OFS_TXD, 8'h22);
        wr_reg(OFS_TRIG, 8'h20);
        wr_reg(OFS_TRIG, 8'h20);
        wr_reg(OFS_TXD, 8'h33);
        chk_reg("stat0 pending", OFS_STAT0, 8'h61);
        settle(50);
        check("frame count", u_node.seen_q.size(), n + 3);
        check("first data", u_node.seen_q[n], 9'h011);
        check("break next", u_node.seen_q[n + 1], 9'h100);
        check("late data", u_node.seen_q[n + 2], 9'h033);
        @(posedge clk);
        rxe <= 1'b0;
        chk_reg("stat0 rx off", OFS_STAT0, 8'h00);
    endtask
    task automatic t_consist();
        @(posedge clk);
        cerr <= 1'b1;
        @(posedge clk);
        cerr <= 1'b0;
        chk_reg("dce flag", OFS_STAT1, 8'h08);
        wr_reg(OFS_TRIG, 8'h20);
        chk_reg("btx blocked", OFS_STAT0, 8'h00);
        @(posedge clk);
        cmode <= 1'b1;
        wr_reg(OFS_TRIG, 8'h20);
        chk_reg("btx check mode", OFS_STAT0, 8'h20);
        @(posedge clk);
        txe <= 1'b0;
        chk_reg("stat0 tx off", OFS_STAT0, 8'h00);
        wr_reg(OFS_STAT0, 8'hFF);
        chk_reg("stat0 write on", OFS_STAT0, 8'h00);
        @(posedge clk);
        pwr <= 1'b0;
        wr_reg(OFS_STAT0, 8'h63);
        chk_reg("stat0 write off", OFS_STAT0, 8'h63);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {arst_n, wr, rd, pwr, rxe, txe, bmode, cmode, cerr} = '0;
        addr = '0;
        wdata = '0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        chk_reg("stat0 reset", OFS_STAT0, STAT0_RST);
        chk_reg("unmapped", 5'h1C, 8'h00);
        @(posedge clk);
        // Triggers only with power and the matching enable set
        {pwr, rxe, txe} <= 3'b111;
        t_brk_tx();
        t_abort();
        t_mode1();
        t_order();
        t_consist();
        print_verdict();
    end
endmodule
